/* core/asf_regs.sv */
// Angle, status and fault register bank behind a serial read/write port
`timescale 1ns/1ps
`include "asf_params.svh"

module asf_regs #(
  parameter int FRAME_BITS = `ASF_FRAME_BITS
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Serial port pins
  input wire logic spi_clk_in,
  input wire logic spi_sel_n_in,
  input wire logic spi_mosi_in,
  output logic spi_miso_out,
  output logic spi_miso_oe_out,
  // Sensing core
  input wire logic [`ASF_ANG_WIDTH-1:0] angle_in,
  input wire asf_pkg::asf_fault_src_t fault_src_in,
  input wire asf_pkg::asf_status_src_t status_src_in,
  input wire logic caution_unmasked_in,
  input wire logic [11:0] fault_mask_in,
  // Clear pulses seen by the core
  output logic special_clear_out
);

  // Pin synchronisers, two stages each
  logic [1:0] clk_sync;
  logic [1:0] sel_sync;
  logic [1:0] mosi_sync;
  logic clk_prev;
  logic clk_rise;
  logic clk_fall;
  logic sel_active;

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      clk_sync <= 2'b00;
      sel_sync <= 2'b11;
      mosi_sync <= 2'b00;
      clk_prev <= 1'b0;
    end
    else
    begin
      clk_sync <= {clk_sync[0], spi_clk_in};
      sel_sync <= {sel_sync[0], spi_sel_n_in};
      mosi_sync <= {mosi_sync[0], spi_mosi_in};
      clk_prev <= clk_sync[1];
    end
  end

  // Edges are found on the second stage only
  assign clk_rise = clk_sync[1] & ~clk_prev;
  assign clk_fall = ~clk_sync[1] & clk_prev;
  assign sel_active = ~sel_sync[1];

  // Register contents
  logic [11:0] fault_latch;
  logic [11:0] fault_seen;
  logic special_done;
  logic boot_done;
  logic startup_finished;
  logic [15:0] angle_word;
  logic [15:0] status_word;
  logic [15:0] fault_word;
  logic fault_summary;
  logic undervoltage_now;
  logic [11:0] fault_set;

  // Serial frame state
  asf_pkg::asf_spi_state_t state;
  logic [`ASF_CNT_WIDTH-1:0] bit_cnt;
  logic [15:0] rx_shift;
  logic [15:0] tx_shift;
  logic [15:0] reply;
  logic frame_done;
  logic is_write;
  logic [6:0] frame_addr;
  logic [7:0] frame_data;
  logic status_clear;
  logic fault_wipe;
  logic fault_read;

  // Odd fill bit: one when the covered bits hold an even count of ones
  function automatic logic odd_fill(input logic [13:0] bits);
    odd_fill = ~(^bits);
  endfunction

  // Control writes are decoded once and shared by both clear strobes
  function automatic logic ctl_write(input logic done,
                                     input logic wr,
                                     input logic [6:0] addr);
    ctl_write = done & wr & (addr == `ASF_ADDR_CONTROL);
  endfunction

  function automatic logic [15:0] read_mux(input logic [6:0] addr,
                                           input logic [15:0] angle_reading,
                                           input logic [15:0] device_status,
                                           input logic [15:0] flt);
    case (addr)
      `ASF_ADDR_ANGLE: read_mux = angle_reading;
      `ASF_ADDR_STATUS: read_mux = device_status;
      `ASF_ADDR_FAULT: read_mux = flt;
      default: read_mux = 16'h0000;
    endcase
  endfunction

  // Angle word
  always_comb
  begin
    undervoltage_now =
      (fault_src_in.supply_pin_undervoltage
        & ~fault_mask_in[`ASF_FLT_SUPPLY_UV])
      | (fault_src_in.regulator_undervoltage
        & ~fault_mask_in[`ASF_FLT_REG_UV]);
    // Masks gate the latch terms of the summary (not caution_unmasked_in), the undervoltage bit and the caution latch; the other latches still record events
    fault_summary = (|(fault_latch & ~fault_mask_in))
      | caution_unmasked_in;
    angle_word = 16'h0000;
    angle_word[`ASF_ANG_SUMMARY_BIT] = fault_summary;
    angle_word[`ASF_ANG_UV_BIT] = undervoltage_now;
    angle_word[`ASF_ANG_WIDTH-1:0] = angle_in;
    angle_word[`ASF_ANG_CHECK_BIT] =
      odd_fill({fault_summary, undervoltage_now, angle_in});
  end

  // Status word
  always_comb
  begin
    status_word = 16'h0000;
    status_word[15:12] = `ASF_TAG_STATUS;
    status_word[`ASF_STA_DIE_HI:`ASF_STA_DIE_LO] =
      status_src_in.die_number;
    status_word[`ASF_STA_DIR_BIT] =
      status_src_in.turning_direction;
    status_word[`ASF_STA_FAST_BIT] =
      status_src_in.too_fast_for_sleep;
    status_word[`ASF_STA_SPECIAL_BIT] = special_done;
    status_word[`ASF_STA_BOOT_DONE_BIT] = boot_done;
    status_word[`ASF_STA_LOGIC_TEST_BIT] =
      status_src_in.logic_selftest_running;
    status_word[`ASF_STA_FRONT_TEST_BIT] =
      status_src_in.front_end_test_running;
    status_word[`ASF_STA_BOOT_BIT] = status_src_in.boot_active;
    // Boot done may be cleared by software, so validity uses its own record
    status_word[`ASF_STA_VALID_BIT] = status_src_in.loop_locked
      & startup_finished & ~status_src_in.boot_active;
    fault_word = {`ASF_TAG_FAULT, fault_latch};
  end

  // Fault set terms, the undervoltage ones are levels that keep setting
  always_comb
  begin
    fault_set = 12'h000;
    fault_set[11] = caution_unmasked_in
      & ~fault_mask_in[`ASF_FLT_CAUTION];
    fault_set[10] = fault_src_in.logic_test_fail
      | fault_src_in.front_end_test_fail;
    fault_set[9] = fault_src_in.averaging_overrun;
    fault_set[8] = fault_src_in.quadrature_integrity_fault;
    fault_set[7] = fault_src_in.loop_lock_lost;
    fault_set[6] = fault_src_in.zero_crossing_timeout;
    fault_set[5] = fault_src_in.nvm_uncorrectable;
    fault_set[4] = fault_src_in.hf_watchdog_trip
      | fault_src_in.lf_watchdog_trip;
    fault_set[3] = fault_src_in.supply_pin_undervoltage;
    fault_set[2] = fault_src_in.regulator_undervoltage;
    fault_set[1] = fault_src_in.field_too_weak;
    fault_set[0] = fault_src_in.hard_reset_done;
  end

  // Frame fields
  assign is_write = rx_shift[15];
  assign frame_addr = rx_shift[14:8];
  assign frame_data = rx_shift[7:0];
  // Short frames never reach done, so they can clear nothing
  assign status_clear = ctl_write(frame_done, is_write, frame_addr)
    & frame_data[`ASF_CTL_STATUS_CLEAR_BIT];
  assign fault_wipe = ctl_write(frame_done, is_write, frame_addr)
    & frame_data[`ASF_CTL_FAULT_WIPE_BIT];
  assign fault_read = frame_done & ~is_write
    & (frame_addr == `ASF_ADDR_FAULT);

  // Serial shifting: sample on rising edge, shift out on falling edge
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      state <= asf_pkg::ASF_IDLE;
      bit_cnt <= '0;
      rx_shift <= 16'h0000;
      tx_shift <= 16'h0000;
    end
    else
    begin
      case (state)
        asf_pkg::ASF_IDLE:
        begin
          bit_cnt <= '0;
          if (sel_active)
          begin
            tx_shift <= reply;
            state <= asf_pkg::ASF_SHIFT;
          end
        end
        asf_pkg::ASF_SHIFT:
        begin
          if (!sel_active)
            state <= asf_pkg::ASF_IDLE;
          else if (clk_rise)
          begin
            rx_shift <= {rx_shift[14:0], mosi_sync[1]};
            bit_cnt <= bit_cnt + 1'b1;
            if (bit_cnt == `ASF_CNT_WIDTH'(FRAME_BITS - 1))
              state <= asf_pkg::ASF_DONE;
          end
          else if (clk_fall)
            tx_shift <= {tx_shift[14:0], 1'b0};
        end
        asf_pkg::ASF_DONE:
        begin
          // Extra clocks are ignored; the frame ends on deselect
          if (!sel_active)
            state <= asf_pkg::ASF_IDLE;
        end
        default: state <= asf_pkg::ASF_IDLE;
      endcase
    end
  end

  // One pulse per completed frame, counted once FRAME_BITS bits are in, even if more clocks follow
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      frame_done <= 1'b0;
    else
      frame_done <= (state == asf_pkg::ASF_DONE) & ~sel_active;
  end

  // Read data is captured at frame end and returned in the next frame
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      reply <= 16'h0000;
    else if (frame_done & ~is_write)
      reply <= read_mux(frame_addr, angle_word, status_word, fault_word);
  end

  // Miso comes straight from a flop, so it cannot glitch mid-bit
  assign spi_miso_out = tx_shift[15];
  assign spi_miso_oe_out = sel_active;

  // Fault latches: new sets always win over a wipe
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      fault_latch <= `ASF_FLT_RESET_VALUE;
    else if (fault_wipe)
      fault_latch <= (fault_latch & ~fault_seen) | fault_set;
    else
      fault_latch <= fault_latch | fault_set;
  end

  // Flags the host has been shown; only these may be wiped
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      fault_seen <= 12'h000;
    else if (fault_read)
      fault_seen <= fault_latch;
    else if (fault_wipe)
      fault_seen <= 12'h000;
  end

  // Special command done flag; finish wins over start and clear
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      special_done <= 1'b0;
    else if (status_src_in.special_finish)
      special_done <= 1'b1;
    else if (status_src_in.special_start | status_clear)
      special_done <= 1'b0;
  end

  // Boot done is sticky; the core's completion pulse wins over a clear
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      boot_done <= 1'b0;
    else if (status_src_in.boot_complete)
      boot_done <= 1'b1;
    else if (status_clear)
      boot_done <= 1'b0;
  end

  // Startup record kept apart from boot done, which software may clear
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      startup_finished <= 1'b0;
    else if (status_src_in.boot_complete)
      startup_finished <= 1'b1;
  end

  // Registered so the core sees one clean strobe per clear request
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      special_clear_out <= 1'b0;
    else
      special_clear_out <= status_clear;
  end

endmodule

/* core/asf_params.svh */
// Register offsets, field positions, tags and frame constants
`ifndef ASF_PARAMS_SVH
`define ASF_PARAMS_SVH

// Register byte offsets on the serial port
`define ASF_ADDR_CONTROL 7'h1e
`define ASF_ADDR_ANGLE 7'h20
`define ASF_ADDR_STATUS 7'h22
`define ASF_ADDR_FAULT 7'h24

// Register tags in bits 15:12
`define ASF_TAG_STATUS 4'h8
`define ASF_TAG_FAULT 4'ha

// Angle word fields
`define ASF_ANG_SUMMARY_BIT 14
`define ASF_ANG_UV_BIT 13
`define ASF_ANG_CHECK_BIT 12
`define ASF_ANG_WIDTH 12

// Status word fields
`define ASF_STA_DIE_HI 9
`define ASF_STA_DIE_LO 8
`define ASF_STA_DIR_BIT 7
`define ASF_STA_FAST_BIT 6
`define ASF_STA_SPECIAL_BIT 5
`define ASF_STA_BOOT_DONE_BIT 4
`define ASF_STA_LOGIC_TEST_BIT 3
`define ASF_STA_FRONT_TEST_BIT 2
`define ASF_STA_BOOT_BIT 1
`define ASF_STA_VALID_BIT 0

// Control byte bits (upper byte of the control register)
`define ASF_CTL_STATUS_CLEAR_BIT 2
`define ASF_CTL_FAULT_WIPE_BIT 0

// Fault latch bits
`define ASF_FLT_CAUTION 11
`define ASF_FLT_SUPPLY_UV 3
`define ASF_FLT_REG_UV 2
`define ASF_FLT_RESET 0
`define ASF_FLT_RESET_VALUE 12'h001

// Serial frame
`define ASF_FRAME_BITS 16
`define ASF_CNT_WIDTH 5

`endif

/* core/asf_pkg.sv */
// Types shared by the angle, status and fault register bank
package asf_pkg;

  // Fault sources from the sensing core, same clock domain
  typedef struct packed {
    logic logic_test_fail;
    logic front_end_test_fail;
    logic averaging_overrun;
    logic quadrature_integrity_fault;
    logic loop_lock_lost;
    logic zero_crossing_timeout;
    logic nvm_uncorrectable;
    logic hf_watchdog_trip;
    logic lf_watchdog_trip;
    logic supply_pin_undervoltage;
    logic regulator_undervoltage;
    logic field_too_weak;
    logic hard_reset_done;
  } asf_fault_src_t;

  // Status sources from the sensing core, same clock domain
  typedef struct packed {
    logic [1:0] die_number;
    logic turning_direction;
    logic too_fast_for_sleep;
    logic logic_selftest_running;
    logic front_end_test_running;
    logic boot_active;
    logic loop_locked;
    logic boot_complete;
    logic special_start;
    logic special_finish;
  } asf_status_src_t;

  // Serial transfer states
  typedef enum logic [1:0] {
    ASF_IDLE = 2'b00,
    ASF_SHIFT = 2'b01,
    ASF_DONE = 2'b10
  } asf_spi_state_t;

endpackage

/* dv/asf_regs_assertions.sv */
// Checker for the serial port pins and the clear pulse of the bank
`timescale 1ns/1ps
module asf_regs_assertions #(
  parameter int FRAME_BITS = 16
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Serial port
  input wire logic spi_clk_in,
  input wire logic spi_sel_n_in,
  input wire logic spi_miso_out,
  input wire logic spi_miso_oe_out,
  // Clear pulse
  input wire logic special_clear_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  property p_oe_off;
    spi_sel_n_in [*3] |-> !spi_miso_oe_out;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("miso enabled while deselected");
  property p_oe_on;
    !spi_sel_n_in [*3] |-> spi_miso_oe_out;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("miso not enabled while selected");
  property p_oe_rise;
    $rose(spi_miso_oe_out) |-> !spi_sel_n_in && !$past(spi_sel_n_in);
  endproperty
  a_oe_rise: assert property (p_oe_rise)
    else $error("miso enabled too early");
  property p_oe_fall;
    $fell(spi_miso_oe_out) |-> spi_sel_n_in && $past(spi_sel_n_in);
  endproperty
  a_oe_fall: assert property (p_oe_fall)
    else $error("miso released too early");
  // Sync latency means miso may move only a few cycles after a fall
  property p_miso_hold;
    spi_clk_in [*5] |-> $stable(spi_miso_out);
  endproperty
  a_miso_hold: assert property (p_miso_hold)
    else $error("miso moved while serial clock high");
  property p_clr_pulse;
    special_clear_out |=> !special_clear_out;
  endproperty
  a_clr_pulse: assert property (p_clr_pulse)
    else $error("status clear longer than one cycle");
  property p_clr_frame;
    special_clear_out |-> spi_sel_n_in && $past(spi_sel_n_in, 2);
  endproperty
  a_clr_frame: assert property (p_clr_frame)
    else $error("status clear inside a frame");
  property p_reset_quiet;
    $fell(rst_in) |-> !spi_miso_oe_out && !special_clear_out;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active right after reset");
endmodule

bind asf_regs asf_regs_assertions #(.FRAME_BITS(FRAME_BITS)) i_asf_chk (
  .mclk_in(mclk_in), .rst_in(rst_in), .spi_clk_in(spi_clk_in),
  .spi_sel_n_in(spi_sel_n_in), .spi_miso_out(spi_miso_out),
  .spi_miso_oe_out(spi_miso_oe_out),
  .special_clear_out(special_clear_out));

/* dv/asf_spi_host.sv */
// Host model: mode 0 serial master, 16-bit frames, MSB first
`timescale 1ns/1ps
module asf_spi_host (
  // Clock
  input wire logic mclk_in,
  // Device pins
  input wire logic miso_in,
  input wire logic miso_oe_in,
  output logic sclk_out,
  output logic sel_n_out,
  output logic mosi_out
);
  initial
  begin
    sclk_out = 1'b0;
    sel_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // Clock stands low between frames; undriven miso reads as unknown
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    @(posedge mclk_in);
    #1 sel_n_out = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      mosi_out = tx[i];
      #62.5 sclk_out = 1'b1;
      rx[i] = miso_oe_in ? miso_in : 1'bx;
      #62.5 sclk_out = 1'b0;
    end
    #62.5 sel_n_out = 1'b1;
    mosi_out = ~mosi_out;
    repeat (10) @(posedge mclk_in);
    #1;
  endtask
endmodule

/* dv/testbench.sv */
// Self-checking bench for the angle, status and fault register bank
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [11:0] angle_reading;
    logic sup;
    logic reg_uv;
    logic [11:0] mask;
    logic [15:0] word;
  } asf_row_t;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic spi_clk, spi_sel_n, spi_mosi, spi_miso, spi_oe, clr;
  logic [11:0] angle = 12'h000;
  logic [11:0] mask = 12'hfff;
  logic caution = 1'b0;
  asf_pkg::asf_fault_src_t fsrc = '0;
  asf_pkg::asf_status_src_t ssrc = '0;
  logic [15:0] rx;
  int err_total = 0;
  int compares = 0;
  int clr_cnt = 0;
  int b;
  asf_row_t rows [6] = '{
    '{12'h000, 1'b0, 1'b0, 12'hfff, 16'h1000},
    '{12'h001, 1'b0, 1'b0, 12'hfff, 16'h0001},
    '{12'hfff, 1'b0, 1'b0, 12'hffe, 16'h4fff},
    '{12'h800, 1'b0, 1'b1, 12'hffb, 16'h6800},
    '{12'h0a5, 1'b0, 1'b1, 12'hfff, 16'h10a5},
    '{12'h123, 1'b1, 1'b0, 12'hff7, 16'h7123}};
  always #5 mclk_in = ~mclk_in;
  // Counted on the falling edge, where the strobe has settled
  always @(negedge mclk_in) if (clr === 1'b1) clr_cnt++;
  asf_regs i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .spi_clk_in(spi_clk),
    .spi_sel_n_in(spi_sel_n), .spi_mosi_in(spi_mosi),
    .spi_miso_out(spi_miso), .spi_miso_oe_out(spi_oe), .angle_in(angle),
    .fault_src_in(fsrc), .status_src_in(ssrc),
    .caution_unmasked_in(caution), .fault_mask_in(mask),
    .special_clear_out(clr));
  asf_spi_host i_host (.mclk_in(mclk_in), .miso_in(spi_miso),
    .miso_oe_in(spi_oe), .sclk_out(spi_clk), .sel_n_out(spi_sel_n),
    .mosi_out(spi_mosi));
  task automatic tick;
    @(posedge mclk_in);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, exp, msk);
    compares++;
    if ((got & msk) !== (exp & msk))
    begin
      err_total++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Reply lags one frame, so a read of an unmapped place fetches it
  task automatic rd(input logic [6:0] addr);
    i_host.xfer({1'b0, addr, 8'h00}, rx);
    chk(rx, 16'h0000, 16'hffff);
    i_host.xfer(16'h7f00, rx);
  endtask
  task automatic wr(input logic [7:0] d);
    i_host.xfer({1'b1, 7'h1e, d}, rx);
  endtask
  task automatic results;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #500000;
    err_total++;
    results();
  end
  initial
  begin
    repeat (10) tick();
    rst_in = 1'b0;
    foreach (rows[i])
    begin
      angle = rows[i].angle_reading;
      fsrc.supply_pin_undervoltage = rows[i].sup;
      fsrc.regulator_undervoltage = rows[i].reg_uv;
      mask = rows[i].mask;
      rd(7'h20);
      chk(rx, rows[i].word, 16'hffff);
    end
    fsrc = '0;
    ssrc.die_number = 2'b10;
    ssrc.turning_direction = 1'b1;
    ssrc.too_fast_for_sleep = 1'b1;
    ssrc.logic_selftest_running = 1'b1;
    ssrc.loop_locked = 1'b1;
    ssrc.boot_complete = 1'b1;
    ssrc.special_finish = 1'b1;
    tick();
    ssrc.boot_complete = 1'b0;
    ssrc.special_finish = 1'b0;
    rd(7'h22);
    chk(rx, 16'h82f9, 16'hffff);
    ssrc.special_start = 1'b1;
    tick();
    ssrc.special_start = 1'b0;
    rd(7'h22);
    chk(rx, 16'h82d9, 16'hffff);
    wr(8'h04);
    chk(16'(clr_cnt), 16'h0001, 16'hffff);
    rd(7'h22);
    chk(rx, 16'h82c9, 16'hffff);
    ssrc.boot_active = 1'b1;
    ssrc.front_end_test_running = 1'b1;
    rd(7'h22);
    chk(rx, 16'h82ce, 16'hffff);
    mask = 12'h000;
    rd(7'h24);
    chk(rx, 16'ha00d, 16'hffff);
    wr(8'h01);
    rd(7'h24);
    chk(rx, 16'ha000, 16'hffff);
    for (int i = 0; i < 14; i++)
    begin
      b = i == 13 ? 11 : i < 4 ? i : i < 6 ? 4 : i == 12 ? 10 : i - 1;
      if (i == 13)
        caution = 1'b1;
      else
        fsrc[i] = 1'b1;
      tick();
      fsrc = '0;
      caution = 1'b0;
      rd(7'h24);
      chk(rx, 16'ha000 | (16'h0001 << b), 16'hffff);
      // Each source above maps to a latch; the two watchdogs share bit 4 and the two test fails share bit 10
      wr(8'h01);
    end
    mask[11] = 1'b1;
    caution = 1'b1;
    rd(7'h24);
    chk(rx, 16'ha000, 16'hffff);
    caution = 1'b0;
    fsrc.field_too_weak = 1'b1;
    tick();
    fsrc = '0;
    rd(7'h24);
    chk(rx, 16'ha002, 16'hffff);
    i_host.xfer({1'b1, 7'h24, 8'h01}, rx);
    rd(7'h24);
    chk(rx, 16'ha002, 16'hffff);
    fsrc.loop_lock_lost = 1'b1;
    tick();
    fsrc = '0;
    wr(8'h01);
    rd(7'h24);
    chk(rx, 16'ha080, 16'hffff);
    fsrc.regulator_undervoltage = 1'b1;
    wr(8'h01);
    rd(7'h24);
    chk(rx, 16'ha004, 16'hffff);
    fsrc = '0;
    rst_in = 1'b1;
    repeat (2) tick();
    rst_in = 1'b0;
    rd(7'h24);
    chk(rx, 16'ha001, 16'hffff);
    rd(7'h22);
    chk(rx, 16'h82ce, 16'hffff);
    results();
  end
endmodule
